// >>> core/avcc_conditioner.v
// analog velocity command conditioner with avalon-mm register slave
//
// Functional notes
// R1 - single-ended or differential command input
// R2 - differential command is input one minus two
// R3 - full scale 10 V gives velocity gain
// R4 - velocity gain held as rps times 240
// R5 - three offsets, clamped, subtracted from input
// R6 - offsets held as volts times 2730
// R7 - deadband zeroes small input one, differential
// R8 - run switch closed passes command
// R9 - run switch open forces zero command
// R10 - direction switch closed reverses command sign
// R11 - connection type 0 single, 1 differential
// R12 - input two function 2 torque, 3 unused
// R13 - 10 V on input two gives torque gain
// R14 - torque gain held as amps times 100
// R15 - reached indication on output four
// R16 - output four selected by second digit
// R17 - digit B: closed while not reached
// R18 - other digit: closed when reached
// R19 - digit 3: output four general purpose
// R20 - reached when error within ripple range
// R21 - offset, deadband, gain, then direction, run
`timescale 1ns/1ns
`default_nettype none
`include "avcc_consts.vh"

module avcc_conditioner (
  // system
  input wire clk_sys,
  input wire rst_n,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // digitised analog samples, 2730 counts per volt
  input wire sample_valid,
  input wire signed [15:0] analog_in_one,
  input wire signed [15:0] analog_in_two,
  // switch pins, high means closed
  input wire run_stop_switch,
  input wire direction_switch,
  // measured motor velocity, rps times 240
  input wire signed [15:0] actual_velocity,
  // conditioned outputs
  output reg signed [15:0] velocity_cmd,
  output reg velocity_cmd_valid,
  output reg signed [15:0] torque_limit,
  output reg torque_limit_en,
  output reg velocity_reached_out
);

  localparam signed [33:0] FS34 = {2'b00, `AVCC_FS_COUNTS};
  localparam [31:0] MV_FULL = `AVCC_MV_PER_V;
  localparam [31:0] CPV_FULL = `AVCC_COUNTS_PER_V;
  // 28 bits hold the largest millivolt product
  localparam [27:0] MV28 = MV_FULL[27:0];
  localparam [27:0] CPV28 = CPV_FULL[27:0];

  // ==========================================================
  // helpers
  // out-of-range gain, offset and ripple writes are clamped, never refused
  function [15:0] clamp16;
    input signed [31:0] v;
    input signed [31:0] lo;
    input signed [31:0] hi;
    begin
      if (v < lo) begin
        clamp16 = lo[15:0];
      end else if (v > hi) begin
        clamp16 = hi[15:0];
      end else begin
        clamp16 = v[15:0];
      end
    end
  endfunction

  // symmetric so that a later negation cannot overflow
  function signed [15:0] sat16;
    input signed [33:0] v;
    begin
      if (v > $signed({2'b00, `AVCC_SAT16_MAX})) begin
        sat16 = 16'sh7fff;
      end else if (v < -$signed({2'b00, `AVCC_SAT16_MAX})) begin
        sat16 = -16'sh7fff;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  // ==========================================================
  // registers
  reg conn_type;
  reg [1:0] in_two_func;
  reg signed [15:0] velocity_gain;
  reg signed [15:0] offset_in_one;
  reg signed [15:0] offset_in_two;
  reg signed [15:0] offset_differential;
  reg [7:0] deadband_in_one;
  reg [7:0] deadband_differential;
  reg signed [15:0] torque_gain;
  reg [15:0] output_mode_setting;
  reg [15:0] ripple_range;
  reg gp_out;
  reg reached;
  reg run_meta;
  reg run_sync;
  reg dir_meta;
  reg dir_sync;

  reg [31:0] rd_mux;
  wire [31:0] be_mask;
  wire [31:0] merged;
  wire signed [31:0] m_s16;
  wire signed [31:0] m_u16;
  wire bus_take;

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign merged = (rd_mux & ~be_mask) | (avs_writedata & be_mask);
  assign m_s16 = {{16{merged[15]}}, merged[15:0]};
  assign m_u16 = {16'h0000, merged[15:0]};
  // one answer per request; the idle cycle after it re-arms
  assign bus_take = (avs_read | avs_write) & avs_waitrequest;

  always @* begin
    case (avs_address & 8'hfc)
      `AVCC_REG_CONFIG: rd_mux = {26'h0, in_two_func, 3'h0, conn_type};
      `AVCC_REG_VEL_GAIN: rd_mux = {16'h0000, velocity_gain};
      `AVCC_REG_OFFSET_ONE: rd_mux = {16'h0000, offset_in_one};
      `AVCC_REG_OFFSET_TWO: rd_mux = {16'h0000, offset_in_two};
      `AVCC_REG_OFFSET_DIFF: rd_mux = {16'h0000, offset_differential};
      `AVCC_REG_DEADBAND_ONE: rd_mux = {24'h0, deadband_in_one};
      `AVCC_REG_DEADBAND_DIFF: rd_mux = {24'h0, deadband_differential};
      `AVCC_REG_TORQUE_GAIN: rd_mux = {16'h0000, torque_gain};
      `AVCC_REG_OUTPUT_MODE: rd_mux = {16'h0000, output_mode_setting};
      `AVCC_REG_RIPPLE: rd_mux = {16'h0000, ripple_range};
      `AVCC_REG_GP_OUT: rd_mux = {31'h0, gp_out};
      `AVCC_REG_STATUS: rd_mux = {28'h0, torque_limit_en, dir_sync, run_sync, reached};
      `AVCC_REG_VEL_CMD: rd_mux = {16'h0000, velocity_cmd};
      `AVCC_REG_TORQUE: rd_mux = {16'h0000, torque_limit};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // bus slave
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      conn_type <= `AVCC_RST_TYPE;
      in_two_func <= `AVCC_RST_FUNC;
      velocity_gain <= `AVCC_RST_VEL_GAIN;
      offset_in_one <= 16'h0000;
      offset_in_two <= 16'h0000;
      offset_differential <= 16'h0000;
      deadband_in_one <= 8'h00;
      deadband_differential <= 8'h00;
      torque_gain <= `AVCC_RST_TORQUE_GAIN;
      output_mode_setting <= `AVCC_RST_OUTPUT_MODE;
      ripple_range <= 16'h0000;
      gp_out <= 1'b0;
    end else begin
      // registered answer: exactly one wait cycle per request
      avs_waitrequest <= ~bus_take;
      if (bus_take && avs_read) begin
        avs_readdata <= rd_mux;
      end
      if (bus_take && avs_write) begin
        case (avs_address & 8'hfc)
          `AVCC_REG_CONFIG: begin
            // R11 connection type select
            conn_type <= merged[`AVCC_CFG_TYPE_BIT];
            // R12 function code, zero lifted to one
            if (merged[`AVCC_CFG_FUNC_MSB:`AVCC_CFG_FUNC_LSB] < `AVCC_FUNC_MIN) begin
              in_two_func <= `AVCC_FUNC_MIN;
            end else begin
              in_two_func <= merged[`AVCC_CFG_FUNC_MSB:`AVCC_CFG_FUNC_LSB];
            end
          end
          `AVCC_REG_VEL_GAIN: begin
            // R4 stored as rps times 240, -100..100 rps
            velocity_gain <= clamp16(m_s16, -$signed(`AVCC_VEL_GAIN_MAX),
                                     $signed(`AVCC_VEL_GAIN_MAX));
          end
          `AVCC_REG_OFFSET_ONE: begin
            // R6 stored as volts times 2730, -10..10 V
            offset_in_one <= clamp16(m_s16, -$signed(`AVCC_OFFSET_MAX),
                                     $signed(`AVCC_OFFSET_MAX));
          end
          `AVCC_REG_OFFSET_TWO: begin
            offset_in_two <= clamp16(m_s16, -$signed(`AVCC_OFFSET_MAX),
                                     $signed(`AVCC_OFFSET_MAX));
          end
          `AVCC_REG_OFFSET_DIFF: begin
            offset_differential <= clamp16(m_s16, -$signed(`AVCC_OFFSET_MAX),
                                           $signed(`AVCC_OFFSET_MAX));
          end
          `AVCC_REG_DEADBAND_ONE: deadband_in_one <= merged[7:0];
          `AVCC_REG_DEADBAND_DIFF: deadband_differential <= merged[7:0];
          `AVCC_REG_TORQUE_GAIN: begin
            // R14 stored as amps times 100
            torque_gain <= clamp16(m_s16, -$signed(`AVCC_TORQUE_GAIN_MAX),
                                   $signed(`AVCC_TORQUE_GAIN_MAX));
          end
          `AVCC_REG_OUTPUT_MODE: output_mode_setting <= merged[15:0];
          `AVCC_REG_RIPPLE: begin
            // R20 ripple 0..136 rps, times 240
            ripple_range <= clamp16(m_u16, 32'sh0, $signed(`AVCC_RIPPLE_MAX));
          end
          `AVCC_REG_GP_OUT: gp_out <= merged[0];
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // switch synchronisers
  // pins are asynchronous to clk_sys; only the second flop is read
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      run_meta <= 1'b0;
      run_sync <= 1'b0;
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      run_meta <= run_stop_switch;
      run_sync <= run_meta;
      dir_meta <= direction_switch;
      dir_sync <= dir_meta;
    end
  end

  // ==========================================================
  // conditioning pipeline, one stage per step but direction and run share the last, gain split into multiply and divide stages
  reg [3:0] stage_v;
  reg signed [17:0] s1_cmd;
  reg signed [17:0] s1_trq;
  reg signed [17:0] s2_cmd;
  reg signed [17:0] s2_trq;
  reg signed [33:0] s3_vprod;
  reg signed [33:0] s3_tprod;
  reg signed [15:0] s4_vq;
  reg signed [15:0] s4_tq;

  wire signed [17:0] in_one_x;
  wire signed [17:0] in_two_x;
  wire signed [17:0] raw_cmd;
  wire signed [17:0] sel_off;
  wire [17:0] cmd_mag;
  wire [27:0] mag_mv;
  wire [27:0] band_lim;
  wire torque_active;

  assign in_one_x = {{2{analog_in_one[15]}}, analog_in_one};
  assign in_two_x = {{2{analog_in_two[15]}}, analog_in_two};
  // R1 R2 pick single-ended or differential source
  assign raw_cmd = conn_type ? (in_one_x - in_two_x) : in_one_x;
  assign sel_off = conn_type ? {{2{offset_differential[15]}}, offset_differential}
                             : {{2{offset_in_one[15]}}, offset_in_one};
  assign cmd_mag = s1_cmd[17] ? -s1_cmd : s1_cmd;
  // compare in millivolt units to avoid a divider
  assign mag_mv = {10'h000, cmd_mag} * MV28;
  assign band_lim = (conn_type ? {20'h00000, deadband_differential}
                               : {20'h00000, deadband_in_one}) * CPV28;
  // torque limit only in single-ended connection
  assign torque_active = (in_two_func == `AVCC_FUNC_TORQUE) && !conn_type;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stage_v <= 4'h0;
      s1_cmd <= 18'h00000;
      s1_trq <= 18'h00000;
      s2_cmd <= 18'h00000;
      s2_trq <= 18'h00000;
      s3_vprod <= 34'h000000000;
      s3_tprod <= 34'h000000000;
      s4_vq <= 16'h0000;
      s4_tq <= 16'h0000;
      velocity_cmd <= 16'h0000;
      velocity_cmd_valid <= 1'b0;
      torque_limit <= 16'h0000;
      torque_limit_en <= 1'b0;
    end else begin
      // one valid bit per stage, so samples may come every cycle
      stage_v <= {stage_v[2:0], sample_valid};
      // R21 step one: offset removal
      // R5 subtract the matching offset
      if (sample_valid) begin
        s1_cmd <= raw_cmd - sel_off;
        s1_trq <= in_two_x - {{2{offset_in_two[15]}}, offset_in_two};
      end
      // R21 step two: deadband
      // R7 within band becomes zero
      if (stage_v[0]) begin
        s2_cmd <= (mag_mv <= band_lim) ? 18'h00000 : s1_cmd;
        // torque path has no deadband
        s2_trq <= s1_trq;
      end
      // R21 step three: gain
      // R3 R13 multiply by gain in display units
      if (stage_v[1]) begin
        s3_vprod <= s2_cmd * velocity_gain;
        s3_tprod <= s2_trq * torque_gain;
      end
      // wide divide in its own stage keeps it off the multiply path
      // R3 R13 full scale 10 V divides out
      if (stage_v[2]) begin
        s4_vq <= sat16(s3_vprod / FS34);
        s4_tq <= sat16(s3_tprod / FS34);
      end
      // R21 last: direction then run gating
      if (stage_v[3]) begin
        if (!run_sync) begin
          // R9 open switch stops the motor
          velocity_cmd <= 16'h0000;
        end else if (dir_sync) begin
          // R8 R10 run reversed
          velocity_cmd <= -s4_vq;
        end else begin
          // R8 run as commanded
          velocity_cmd <= s4_vq;
        end
        // R12 R13 torque limit when selected
        torque_limit <= torque_active ? s4_tq : 16'h0000;
        torque_limit_en <= torque_active;
      end
      velocity_cmd_valid <= stage_v[3];
    end
  end

  // ==========================================================
  // velocity reached on output four
  wire signed [16:0] vel_err;
  wire [16:0] vel_err_mag;
  wire [3:0] out4_digit;

  assign vel_err = {actual_velocity[15], actual_velocity}
                 - {velocity_cmd[15], velocity_cmd};
  assign vel_err_mag = vel_err[16] ? -vel_err : vel_err;
  // R16 second digit from the right
  assign out4_digit = output_mode_setting[`AVCC_OUT4_DIGIT_MSB:`AVCC_OUT4_DIGIT_LSB];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reached <= 1'b0;
      velocity_reached_out <= 1'b0;
    end else begin
      // reached lags actual_velocity by one edge, the pin by two
      // R20 within ripple counts as reached
      // R15 compare actual to target
      reached <= (vel_err_mag <= {1'b0, ripple_range});
      case (out4_digit)
        // R17 inverted: closed while not reached
        `AVCC_OUT4_INVERTED: velocity_reached_out <= ~reached;
        // R19 general purpose output
        `AVCC_OUT4_GENERAL: velocity_reached_out <= gp_out;
        // R18 closed once reached
        default: velocity_reached_out <= reached;
      endcase
    end
  end

endmodule

`default_nettype wire

// >>> core/avcc_consts.vh
// constants for the analog velocity command conditioner
`ifndef AVCC_CONSTS_VH
`define AVCC_CONSTS_VH

// ==========================================================
// register byte offsets
`define AVCC_REG_CONFIG 8'h00
`define AVCC_REG_VEL_GAIN 8'h04
`define AVCC_REG_OFFSET_ONE 8'h08
`define AVCC_REG_OFFSET_TWO 8'h0c
`define AVCC_REG_OFFSET_DIFF 8'h10
`define AVCC_REG_DEADBAND_ONE 8'h14
`define AVCC_REG_DEADBAND_DIFF 8'h18
`define AVCC_REG_TORQUE_GAIN 8'h1c
`define AVCC_REG_OUTPUT_MODE 8'h20
`define AVCC_REG_RIPPLE 8'h24
`define AVCC_REG_GP_OUT 8'h28
`define AVCC_REG_STATUS 8'h2c
`define AVCC_REG_VEL_CMD 8'h30
`define AVCC_REG_TORQUE 8'h34

// ==========================================================
// field positions
`define AVCC_CFG_TYPE_BIT 0
`define AVCC_CFG_FUNC_LSB 4
`define AVCC_CFG_FUNC_MSB 5
`define AVCC_OUT4_DIGIT_LSB 4
`define AVCC_OUT4_DIGIT_MSB 7

// ==========================================================
// reset values
`define AVCC_RST_TYPE 1'h0
`define AVCC_RST_FUNC 2'h3
`define AVCC_RST_VEL_GAIN 16'h12c0
`define AVCC_RST_TORQUE_GAIN 16'h0064
`define AVCC_RST_OUTPUT_MODE 16'h0030

// ==========================================================
// codes
`define AVCC_FUNC_MIN 2'h1
`define AVCC_FUNC_TORQUE 2'h2
`define AVCC_FUNC_UNUSED 2'h3
`define AVCC_OUT4_INVERTED 4'hb
`define AVCC_OUT4_GENERAL 4'h3

// ==========================================================
// scaling: 2730 counts per volt, 240 per rps, 100 per amp
`define AVCC_COUNTS_PER_V 32'h00000aaa
`define AVCC_MV_PER_V 32'h000003e8
`define AVCC_FS_COUNTS 32'h00006aa4
`define AVCC_RPS_SCALE 32'h000000f0
`define AVCC_AMP_SCALE 32'h00000064
`define AVCC_VEL_GAIN_MAX 32'h00005dc0
`define AVCC_OFFSET_MAX 32'h00006aa4
`define AVCC_TORQUE_GAIN_MAX 32'h000007d0
`define AVCC_RIPPLE_MAX 32'h00007f80
`define AVCC_SAT16_MAX 32'h00007fff

`endif

// >>> bench/avcc_chk.sv
// checker for bus answers and sample pipeline timing
`timescale 1ns/1ns
`default_nettype none
module avcc_chk (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sample path
  input wire logic sample_valid,
  input wire logic run_stop_switch,
  input wire logic signed [15:0] velocity_cmd,
  input wire logic velocity_cmd_valid,
  input wire logic signed [15:0] torque_limit,
  input wire logic torque_limit_en
);
  logic [2:0] open_cnt;
  // ==========================================================
  // run switch open streak
  // two sync flops, so five open cycles are surely seen
  always @(posedge clk_sys) begin
    if (!rst_n || run_stop_switch)
      open_cnt <= 3'h0;
    else if (open_cnt != 3'h7)
      open_cnt <= open_cnt + 3'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus request not answered in one cycle");
  a_bus_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_read_hold: assert property (!$fell(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data changed outside an answer");
  a_pipe_latency: assert property (sample_valid |-> ##5 velocity_cmd_valid)
    else $error("result not five cycles after sample");
  a_pipe_cause: assert property (velocity_cmd_valid |-> $past(sample_valid, 5))
    else $error("result without a sample");
  a_cmd_hold: assert property (!velocity_cmd_valid |-> $stable(velocity_cmd))
    else $error("command changed without valid");
  a_run_zero: assert property (velocity_cmd_valid && open_cnt >= 3'h5 |-> velocity_cmd == 16'h0000)
    else $error("command not zero with run switch open");
  a_torque_off: assert property (!torque_limit_en |-> torque_limit == 16'h0000)
    else $error("torque limit nonzero while unused");
endmodule
bind avcc_conditioner avcc_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_valid(sample_valid), .run_stop_switch(run_stop_switch),
  .velocity_cmd(velocity_cmd), .velocity_cmd_valid(velocity_cmd_valid),
  .torque_limit(torque_limit), .torque_limit_en(torque_limit_en));
`default_nettype wire

// >>> bench/avcc_host_model.sv
// host controller model: samples, switch pins and measured speed
`timescale 1ns/1ns
`default_nettype none
module avcc_host_model (
  // system
  input wire logic clk_sys,
  // requests from the bench
  input wire logic send,
  input wire logic signed [15:0] val_one,
  input wire logic signed [15:0] val_two,
  input wire logic run_in,
  input wire logic dir_in,
  input wire logic signed [15:0] speed_in,
  // towards the conditioner
  output var logic sample_valid = 1'b0,
  output var logic signed [15:0] analog_in_one = 16'h0000,
  output var logic signed [15:0] analog_in_two = 16'h0000,
  output var logic run_stop_switch = 1'b0,
  output var logic direction_switch = 1'b0,
  output var logic signed [15:0] actual_velocity = 16'h0000
);
  // converter data is stale off the strobe, so show a moving pattern
  always @(posedge clk_sys) begin
    sample_valid <= send;
    analog_in_one <= send ? val_one : ~analog_in_one;
    analog_in_two <= send ? val_two : ~analog_in_two;
    run_stop_switch <= run_in;
    direction_switch <= dir_in;
    actual_velocity <= speed_in;
  end
endmodule
`default_nettype wire

// >>> bench/avcc_conditioner_tb.sv
// self-checking bench for the analog velocity command conditioner
`timescale 1ns/1ns
`default_nettype none
`include "avcc_consts.vh"
module avcc_conditioner_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic send = 1'b0;
  logic run_in = 1'b0;
  logic dir_in = 1'b0;
  logic signed [15:0] val_one = 16'h0000;
  logic signed [15:0] val_two = 16'h0000;
  logic signed [15:0] speed_in = 16'h0000;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, sample_valid, run_stop_switch, direction_switch;
  wire logic signed [15:0] analog_in_one, analog_in_two, actual_velocity;
  wire logic signed [15:0] velocity_cmd, torque_limit;
  wire logic velocity_cmd_valid, torque_limit_en, velocity_reached_out;
  int miscompares = 0;
  int total_checks = 0;
  int off = 0;
  int db = 0;
  int g = 4800;
  int last = 0;
  bit diff = 1'b0;
  logic [31:0] rdv;

  always #5 clk_sys = ~clk_sys;

  avcc_host_model host (.clk_sys(clk_sys), .send(send), .val_one(val_one),
    .val_two(val_two), .run_in(run_in), .dir_in(dir_in), .speed_in(speed_in),
    .sample_valid(sample_valid), .analog_in_one(analog_in_one),
    .analog_in_two(analog_in_two), .run_stop_switch(run_stop_switch),
    .direction_switch(direction_switch), .actual_velocity(actual_velocity));

  avcc_conditioner uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .analog_in_one(analog_in_one), .analog_in_two(analog_in_two),
    .run_stop_switch(run_stop_switch), .direction_switch(direction_switch),
    .actual_velocity(actual_velocity), .velocity_cmd(velocity_cmd),
    .velocity_cmd_valid(velocity_cmd_valid), .torque_limit(torque_limit),
    .torque_limit_en(torque_limit_en), .velocity_reached_out(velocity_reached_out));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // waitrequest and read data are taken at the rising edge itself
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    if (n == 40)
      miscompares++;
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rdv, exp);
  endtask

  task automatic sw(input logic r, input logic d);
    @(posedge clk_sys);
    run_in <= r;
    dir_in <= d;
    repeat (6) @(posedge clk_sys);
  endtask

  // offset, deadband, gain, then run and direction
  task automatic smp(input int a, input int b);
    int n, v;
    n = 0;
    v = (diff ? a - b : a) - off;
    if ((v < 0 ? -v : v) * 1000 <= db * 2730)
      v = 0;
    v = v * g / 27300;
    if (!run_in)
      v = 0;
    last = dir_in ? -v : v;
    @(posedge clk_sys);
    send <= 1'b1;
    val_one <= 16'(a);
    val_two <= 16'(b);
    @(posedge clk_sys);
    send <= 1'b0;
    @(negedge clk_sys);
    while (velocity_cmd_valid !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    chk(32'(velocity_cmd), last);
  endtask

  task automatic spd(input int v, input logic exp);
    @(posedge clk_sys);
    speed_in <= 16'(v);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({31'h0, velocity_reached_out}, {31'h0, exp});
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`AVCC_REG_CONFIG, 32'h00000030);
    rd(`AVCC_REG_VEL_GAIN, 32'h000012c0);
    rd(`AVCC_REG_TORQUE_GAIN, 32'h00000064);
    rd(`AVCC_REG_OUTPUT_MODE, 32'h00000030);
    rd(8'h3c, 32'h00000000);
    $display("test reset values done");
    sw(1'b1, 1'b0);
    smp(27300, 0);
    smp(-13650, 5);
    off = 2730;
    db = 100;
    bus(1'b1, `AVCC_REG_OFFSET_ONE, 32'h00000aaa);
    bus(1'b1, `AVCC_REG_DEADBAND_ONE, 32'h00000064);
    rd(`AVCC_REG_OFFSET_ONE, 32'h00000aaa);
    smp(3003, 0);
    smp(3004, 0);
    smp(2456, 0);
    sw(1'b1, 1'b1);
    smp(27300, 0);
    sw(1'b0, 1'b0);
    smp(27300, 0);
    sw(1'b1, 1'b0);
    bus(1'b1, `AVCC_REG_VEL_GAIN, 32'h00007fff);
    rd(`AVCC_REG_VEL_GAIN, 32'h00005dc0);
    g = -4800;
    bus(1'b1, `AVCC_REG_VEL_GAIN, 32'h0000ed40);
    smp(30030, 0);
    $display("test single ended done");
    g = 4800;
    diff = 1'b1;
    off = 0;
    db = 0;
    bus(1'b1, `AVCC_REG_VEL_GAIN, 32'h000012c0);
    bus(1'b1, `AVCC_REG_CONFIG, 32'h00000031);
    smp(10000, -3650);
    off = 2730;
    db = 255;
    bus(1'b1, `AVCC_REG_OFFSET_DIFF, 32'h00000aaa);
    bus(1'b1, `AVCC_REG_DEADBAND_DIFF, 32'h000000ff);
    smp(10000, 6570);
    smp(10000, 6574);
    $display("test differential done");
    diff = 1'b0;
    db = 100;
    bus(1'b1, `AVCC_REG_CONFIG, 32'h00000020);
    smp(27300, 13650);
    chk(32'(torque_limit), 32'd50);
    chk({31'h0, torque_limit_en}, 32'h1);
    bus(1'b1, `AVCC_REG_CONFIG, 32'h00000030);
    smp(27300, 27300);
    chk({31'h0, torque_limit_en}, 32'h0);
    $display("test torque limit done");
    bus(1'b1, `AVCC_REG_GP_OUT, 32'h00000001);
    // speed far from target: only the general-purpose bit can drive the pin high
    spd(0, 1'b1);
    bus(1'b1, `AVCC_REG_OUTPUT_MODE, 32'h000000b0);
    spd(last, 1'b0);
    bus(1'b1, `AVCC_REG_RIPPLE, 32'h0000000a);
    spd(last + 10, 1'b0);
    spd(last - 11, 1'b1);
    bus(1'b1, `AVCC_REG_OUTPUT_MODE, 32'h00000000);
    spd(last - 11, 1'b0);
    spd(last - 10, 1'b1);
    $display("test velocity reached done");
    stop_test();
  end

  // run takes a few hundred cycles at most
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
